// ---- design/isp_regs.vh ----
// Register map, field positions and reset values of the interrupt source block
// Operation
// [R1] Each external line catches rising edge when polarity bit is one, falling otherwise.
// [R2] A valid external edge sets its flag regardless of the enable bit.
// [R3] No external request reaches the core while its enable bit is clear.
// [R4] Software clears external flags before re-enabling; hardware never clears them itself.
// [R5] Enabled external lines wake the core from sleep if enabled before sleep.
// [R6] Lines one to three use priority bits; line zero is always high priority.
// [R7] Eight-bit timer mode: wrap from all ones to zero sets overflow flag.
// [R8] Sixteen-bit timer mode: wrap of high and low pair sets overflow flag.
// [R9] Timer overflow request is forwarded only while its enable bit is set.
// [R10] Timer overflow priority follows its own priority bit.
// [R11] Any level change on port-B upper four pins sets the port change flag.
// [R12] Port change request is forwarded only while its enable bit is set.
// [R13] Port change priority follows its own priority bit.
// [R14] Interrupt entry pushes the return program counter onto the return stack.
// [R15] Interrupt entry copies working, status and bank select registers to shadow.
// [R16] A priority bit of one means high priority, zero means low.
// [R17] Second priority register: bits 6,3,2,1,0 hold priorities; bits 7,5,4 read zero.
// [R18] Third priority register holds eight CAN source priorities, bit 7 down to 0.
// [R19] External pins are synchronised before edge detection so each edge flags once.
`ifndef ISP_REGS_VH
`define ISP_REGS_VH

`define ISP_ADDR_W        8
`define ISP_OFF_CTRL_MAIN 8'h00
`define ISP_OFF_CTRL_SEC  8'h04
`define ISP_OFF_CTRL_THD  8'h08
`define ISP_OFF_PRIO_TWO  8'h0c
`define ISP_OFF_PRIO_THR  8'h10
`define ISP_OFF_TIMER     8'h14
`define ISP_OFF_STATUS    8'h18
`define ISP_OFF_MASK      8'h1c
`define ISP_OFF_SHADOW    8'h20
`define ISP_OFF_STACK     8'h24
`define ISP_OFF_CORE      8'h28

// Main control: enables, timer mode and sleep
`define ISP_MAIN_EXT0_EN  0
`define ISP_MAIN_TMR_EN   1
`define ISP_MAIN_PORT_EN  2
`define ISP_MAIN_TMR_16   3
`define ISP_MAIN_SLEEP    4
// Second control: polarity and priorities
`define ISP_SEC_POL_LSB   0
`define ISP_SEC_P2        4
`define ISP_SEC_TMR_P     5
`define ISP_SEC_PORT_P    6
// Third control: line 1..3 enables and priorities 1,3
`define ISP_THD_EN_LSB    0
`define ISP_THD_P1        4
`define ISP_THD_P3        5

`define ISP_PRIO_TWO_MASK 8'h4f
`define ISP_RST_BYTE      8'h00
`define ISP_RST_POL       4'hf

// Flag bit positions in the status register
`define ISP_FLAG_EXT_LSB  0
`define ISP_FLAG_TMR      4
`define ISP_FLAG_PORT     5
`define ISP_NFLAG         6

`define ISP_RESP_OKAY     2'b00
`define ISP_RESP_SLVERR   2'b10

`endif

// ---- design/isp_edge_det.v ----
// Synchroniser and edge detector for one pin
`timescale 1ns/1ns
module isp_edge_det (
  input  wire clk_in,
  input  wire arst_n_in,
  input  wire pin_in,
  input  wire rise_sel_in,
  input  wire any_sel_in,
  output wire hit_out
);
  reg sync1_q;
  reg sync2_q;
  reg last_q;

  // Two-stage synchroniser then history
  always @(posedge clk_in or negedge arst_n_in) begin // [R19]
    if (!arst_n_in) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      last_q  <= 1'b0;
    end else begin
      sync1_q <= pin_in;
      sync2_q <= sync1_q;
      last_q  <= sync2_q;
    end
  end

  assign hit_out = any_sel_in ? (sync2_q ^ last_q) :
                   (rise_sel_in ? (sync2_q & ~last_q) : (~sync2_q & last_q)); // [R1]
endmodule

// ---- design/isp_timer.v ----
// Timer zero counter with 8 and 16 bit overflow
`timescale 1ns/1ns
module isp_timer #(
  parameter W = 16
) (
  input  wire         clk_in,
  input  wire         arst_n_in,
  input  wire         tick_in,
  input  wire         mode16_in,
  output wire [W-1:0] count_out,
  output wire         wrap_out
);
  reg [W-1:0] cnt_q;

  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cnt_q <= {W{1'b0}};
    end else if (tick_in) begin
      if (mode16_in) begin
        cnt_q <= cnt_q + {{(W-1){1'b0}}, 1'b1};
      end else begin
        cnt_q <= {cnt_q[W-1:8], cnt_q[7:0] + 8'h01};
      end
    end
  end

  assign count_out = cnt_q;
  assign wrap_out  = tick_in & (mode16_in ? (&cnt_q) : (&cnt_q[7:0])); // [R7] [R8]
endmodule

// ---- design/isp_irq_top.v ----
// Interrupt source, priority and context save logic with AXI4-Lite registers
`timescale 1ns/1ns
`include "isp_regs.vh"
module isp_irq_top #(
  parameter STACK_DEPTH = 31,
  parameter PC_W        = 21
) (
  input  wire            clk_in,
  input  wire            arst_n_in,
  input  wire [7:0]      s_axi_awaddr_in,
  input  wire            s_axi_awvalid_in,
  output reg             s_axi_awready_out,
  input  wire [31:0]     s_axi_wdata_in,
  input  wire [3:0]      s_axi_wstrb_in,
  input  wire            s_axi_wvalid_in,
  output reg             s_axi_wready_out,
  output reg  [1:0]      s_axi_bresp_out,
  output reg             s_axi_bvalid_out,
  input  wire            s_axi_bready_in,
  input  wire [7:0]      s_axi_araddr_in,
  input  wire            s_axi_arvalid_in,
  output reg             s_axi_arready_out,
  output reg  [31:0]     s_axi_rdata_out,
  output reg  [1:0]      s_axi_rresp_out,
  output reg             s_axi_rvalid_out,
  input  wire            s_axi_rready_in,
  input  wire [3:0]      ext_pin_in,
  input  wire [3:0]      port_b_hi_in,
  input  wire            timer_tick_in,
  input  wire            irq_ack_in,
  input  wire [PC_W-1:0] return_pc_in,
  input  wire [7:0]      working_register_in,
  input  wire [7:0]      core_status_in,
  input  wire [7:0]      bank_select_register_in,
  output reg             high_req_out,
  output reg             low_req_out,
  output reg             wake_out,
  output reg             irq_out
);
  // Control registers
  reg [7:0] ctrl_main_q;
  reg [7:0] ctrl_sec_q;
  reg [7:0] ctrl_thd_q;
  reg [7:0] prio_two_q;
  reg [7:0] prio_thr_q;
  reg [`ISP_NFLAG-1:0] flag_q;
  reg [`ISP_NFLAG-1:0] mask_q;
  reg [3:0] sleep_en_q;
  reg [23:0] shadow_q;
  reg [PC_W-1:0] stack_q [0:STACK_DEPTH-1];
  reg [4:0] sp_q;

  wire [3:0]  ext_hit;
  wire        port_hit;
  wire        tmr_wrap;
  wire [15:0] tmr_count;
  wire [3:0]  ext_en;
  wire [3:0]  ext_prio;

  assign ext_en   = {ctrl_thd_q[`ISP_THD_EN_LSB+2:`ISP_THD_EN_LSB],
                     ctrl_main_q[`ISP_MAIN_EXT0_EN]};
  assign ext_prio = {ctrl_thd_q[`ISP_THD_P3], ctrl_sec_q[`ISP_SEC_P2],
                     ctrl_thd_q[`ISP_THD_P1], 1'b1}; // [R6] [R16]

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_ext
      isp_edge_det u_ext (
        .clk_in      (clk_in),
        .arst_n_in   (arst_n_in),
        .pin_in      (ext_pin_in[g]),
        .rise_sel_in (ctrl_sec_q[`ISP_SEC_POL_LSB+g]),
        .any_sel_in  (1'b0),
        .hit_out     (ext_hit[g])
      );
    end
  endgenerate

  wire [3:0] port_bit_hit;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_port
      isp_edge_det u_port (
        .clk_in      (clk_in),
        .arst_n_in   (arst_n_in),
        .pin_in      (port_b_hi_in[g]),
        .rise_sel_in (1'b0),
        .any_sel_in  (1'b1),
        .hit_out     (port_bit_hit[g])
      );
    end
  endgenerate
  assign port_hit = |port_bit_hit; // [R11]

  isp_timer #(.W(16)) u_tmr (
    .clk_in    (clk_in),
    .arst_n_in (arst_n_in),
    .tick_in   (timer_tick_in),
    .mode16_in (ctrl_main_q[`ISP_MAIN_TMR_16]),
    .count_out (tmr_count),
    .wrap_out  (tmr_wrap)
  );

  // AXI write path
  reg        aw_got_q;
  reg        w_got_q;
  reg [7:0]  aw_addr_q;
  reg [31:0] w_data_q;
  reg [3:0]  w_strb_q;
  wire       aw_fire = s_axi_awvalid_in & s_axi_awready_out;
  wire       w_fire  = s_axi_wvalid_in & s_axi_wready_out;
  wire [7:0] wr_addr = aw_fire ? s_axi_awaddr_in : aw_addr_q;
  wire [31:0] wr_data = w_fire ? s_axi_wdata_in : w_data_q;
  wire        wr_lane = w_fire ? s_axi_wstrb_in[0] : w_strb_q[0];
  wire        wr_go   = (aw_fire | aw_got_q) & (w_fire | w_got_q) & ~s_axi_bvalid_out;
  wire        wr_we   = wr_go & wr_lane;
  reg         wr_hit;

  always @* begin
    case (wr_addr)
      `ISP_OFF_CTRL_MAIN, `ISP_OFF_CTRL_SEC, `ISP_OFF_CTRL_THD, `ISP_OFF_PRIO_TWO,
      `ISP_OFF_PRIO_THR, `ISP_OFF_STATUS, `ISP_OFF_MASK: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      aw_got_q          <= 1'b0;
      w_got_q           <= 1'b0;
      aw_addr_q         <= `ISP_RST_BYTE;
      w_data_q          <= 32'h00000000;
      w_strb_q          <= 4'h0;
      s_axi_awready_out <= 1'b0;
      s_axi_wready_out  <= 1'b0;
      s_axi_bvalid_out  <= 1'b0;
      s_axi_bresp_out   <= `ISP_RESP_OKAY;
    end else begin
      if (aw_fire) begin
        aw_got_q  <= 1'b1;
        aw_addr_q <= s_axi_awaddr_in;
      end
      if (w_fire) begin
        w_got_q  <= 1'b1;
        w_data_q <= s_axi_wdata_in;
        w_strb_q <= s_axi_wstrb_in;
      end
      s_axi_awready_out <= ~aw_got_q & ~aw_fire & ~s_axi_awready_out & ~s_axi_bvalid_out;
      s_axi_wready_out  <= ~w_got_q & ~w_fire & ~s_axi_wready_out & ~s_axi_bvalid_out;
      if (wr_go) begin
        aw_got_q         <= 1'b0;
        w_got_q          <= 1'b0;
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out  <= wr_hit ? `ISP_RESP_OKAY : `ISP_RESP_SLVERR;
      end else if (s_axi_bvalid_out & s_axi_bready_in) begin
        s_axi_bvalid_out <= 1'b0;
      end
    end
  end

  // Register writes, flag set has priority over clear
  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ctrl_main_q <= `ISP_RST_BYTE;
      ctrl_sec_q  <= {4'h0, `ISP_RST_POL};
      ctrl_thd_q  <= `ISP_RST_BYTE;
      prio_two_q  <= `ISP_RST_BYTE;
      prio_thr_q  <= `ISP_RST_BYTE;
      mask_q      <= {`ISP_NFLAG{1'b0}};
      flag_q      <= {`ISP_NFLAG{1'b0}};
    end else begin
      if (wr_we && wr_addr == `ISP_OFF_CTRL_MAIN) ctrl_main_q <= wr_data[7:0];
      if (wr_we && wr_addr == `ISP_OFF_CTRL_SEC)  ctrl_sec_q  <= wr_data[7:0];
      if (wr_we && wr_addr == `ISP_OFF_CTRL_THD)  ctrl_thd_q  <= wr_data[7:0];
      if (wr_we && wr_addr == `ISP_OFF_PRIO_TWO)
        prio_two_q <= wr_data[7:0] & `ISP_PRIO_TWO_MASK; // [R17]
      if (wr_we && wr_addr == `ISP_OFF_PRIO_THR)  prio_thr_q  <= wr_data[7:0]; // [R18]
      if (wr_we && wr_addr == `ISP_OFF_MASK)      mask_q <= wr_data[`ISP_NFLAG-1:0];
      // Write one to clear; only software clears, new events win
      flag_q <= (flag_q & ~((wr_we && wr_addr == `ISP_OFF_STATUS) ?
                 wr_data[`ISP_NFLAG-1:0] : {`ISP_NFLAG{1'b0}})) // [R4]
                | {port_hit, tmr_wrap, ext_hit}; // [R2] [R7] [R8] [R11]
    end
  end

  // Request forwarding with enables and priority
  wire [`ISP_NFLAG-1:0] src_en   = {ctrl_main_q[`ISP_MAIN_PORT_EN],
                                    ctrl_main_q[`ISP_MAIN_TMR_EN], ext_en};
  wire [`ISP_NFLAG-1:0] src_prio = {ctrl_sec_q[`ISP_SEC_PORT_P],
                                    ctrl_sec_q[`ISP_SEC_TMR_P], ext_prio}; // [R10] [R13]
  wire [`ISP_NFLAG-1:0] live     = flag_q & src_en; // [R3] [R9] [R12]
  wire                  entry    = irq_ack_in & (high_req_out | low_req_out);

  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      high_req_out <= 1'b0;
      low_req_out  <= 1'b0;
      wake_out     <= 1'b0;
      irq_out      <= 1'b0;
      sleep_en_q   <= 4'h0;
    end else begin
      high_req_out <= |(live & src_prio); // [R16]
      low_req_out  <= |(live & ~src_prio);
      irq_out      <= |(flag_q & mask_q);
      // Enables latched while awake count for wake-up
      if (!ctrl_main_q[`ISP_MAIN_SLEEP]) sleep_en_q <= ext_en;
      wake_out <= ctrl_main_q[`ISP_MAIN_SLEEP] &
                  |(flag_q[3:0] & sleep_en_q & ext_en); // [R5]
    end
  end

  // Context save on entry
  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      shadow_q <= 24'h000000;
      sp_q     <= 5'h00;
    end else if (entry) begin
      shadow_q <= {bank_select_register_in, core_status_in, working_register_in}; // [R15]
      if (sp_q < STACK_DEPTH[4:0]) sp_q <= sp_q + 5'h01; // [R14]
    end
  end

  always @(posedge clk_in) begin
    if (entry && sp_q < STACK_DEPTH[4:0]) stack_q[sp_q] <= return_pc_in; // [R14]
  end

  // AXI read path
  reg [31:0] rd_word;
  reg        rd_hit;
  wire [PC_W-1:0] top_pc = (sp_q == 5'h00) ? {PC_W{1'b0}} : stack_q[sp_q - 5'h01];
  always @* begin
    rd_hit  = 1'b1;
    rd_word = 32'h00000000;
    case (s_axi_araddr_in)
      `ISP_OFF_CTRL_MAIN: rd_word[7:0] = ctrl_main_q;
      `ISP_OFF_CTRL_SEC:  rd_word[7:0] = ctrl_sec_q;
      `ISP_OFF_CTRL_THD:  rd_word[7:0] = ctrl_thd_q;
      `ISP_OFF_PRIO_TWO:  rd_word[7:0] = prio_two_q;
      `ISP_OFF_PRIO_THR:  rd_word[7:0] = prio_thr_q;
      `ISP_OFF_TIMER:     rd_word[15:0] = tmr_count;
      `ISP_OFF_STATUS:    rd_word[`ISP_NFLAG-1:0] = flag_q;
      `ISP_OFF_MASK:      rd_word[`ISP_NFLAG-1:0] = mask_q;
      `ISP_OFF_SHADOW:    rd_word[23:0] = shadow_q;
      `ISP_OFF_STACK:     rd_word = {{(32-PC_W){1'b0}}, top_pc};
      `ISP_OFF_CORE:      rd_word[4:0] = sp_q;
      default:            rd_hit = 1'b0;
    endcase
  end

  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out  <= 1'b0;
      s_axi_rdata_out   <= 32'h00000000;
      s_axi_rresp_out   <= `ISP_RESP_OKAY;
    end else begin
      s_axi_arready_out <= ~s_axi_arready_out & ~s_axi_rvalid_out & s_axi_arvalid_in;
      if (s_axi_arvalid_in & s_axi_arready_out) begin
        s_axi_rvalid_out <= 1'b1;
        s_axi_rdata_out  <= rd_word;
        s_axi_rresp_out  <= rd_hit ? `ISP_RESP_OKAY : `ISP_RESP_SLVERR;
      end else if (s_axi_rvalid_out & s_axi_rready_in) begin
        s_axi_rvalid_out <= 1'b0;
      end
    end
  end
endmodule

// ---- bench/isp_irq_top_asserts.sv ----
// Concurrent checks on the ports of the interrupt source top
`timescale 1ns/1ns
module isp_chk (
  input wire        clk_in,
  input wire        arst_n_in,
  input wire        s_axi_awvalid_in,
  input wire        s_axi_awready_out,
  input wire        s_axi_wvalid_in,
  input wire        s_axi_wready_out,
  input wire        s_axi_bvalid_out,
  input wire        s_axi_bready_in,
  input wire [1:0]  s_axi_bresp_out,
  input wire        s_axi_arvalid_in,
  input wire        s_axi_arready_out,
  input wire        s_axi_rvalid_out,
  input wire        s_axi_rready_in,
  input wire [31:0] s_axi_rdata_out,
  input wire        high_req_out,
  input wire        low_req_out,
  input wire        wake_out,
  input wire        irq_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  sequence both_taken;
    s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out;
  endsequence
  sequence read_taken;
    s_axi_arvalid_in && s_axi_arready_out;
  endsequence
  sequence recent_write;
    $past(s_axi_wvalid_in && s_axi_wready_out) ||
    $past(s_axi_wvalid_in && s_axi_wready_out, 2) ||
    $past(s_axi_wvalid_in && s_axi_wready_out, 3);
  endsequence
  reset_quiet_a: assert property ($rose(arst_n_in) |->
    !(irq_out || high_req_out || low_req_out || wake_out)) else $error("output high after reset");
  write_resp_a: assert property (both_taken |=> s_axi_bvalid_out) else $error("no write response");
  b_hold_a: assert property (s_axi_bvalid_out && !s_axi_bready_in |=>
    s_axi_bvalid_out && $stable(s_axi_bresp_out)) else $error("write response dropped");
  read_resp_a: assert property (read_taken |=> s_axi_rvalid_out) else $error("no read data");
  r_hold_a: assert property (s_axi_rvalid_out && !s_axi_rready_in |=>
    s_axi_rvalid_out && $stable(s_axi_rdata_out)) else $error("read data dropped");
  ar_pulse_a: assert property (s_axi_arready_out |=> !s_axi_arready_out) else $error("arready held");
  flag_sticky_a: assert property ($fell(irq_out) |-> recent_write) else $error("irq fell alone");
  req_sticky_a: assert property ($fell(high_req_out) |-> recent_write) else $error("req fell");
  wake_sticky_a: assert property ($fell(wake_out) |-> recent_write) else $error("wake fell");
endmodule
bind isp_irq_top isp_chk u_chk (.clk_in, .arst_n_in, .s_axi_awvalid_in, .s_axi_awready_out,
  .s_axi_wvalid_in, .s_axi_wready_out, .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_bresp_out,
  .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rvalid_out, .s_axi_rready_in, .s_axi_rdata_out,
  .high_req_out, .low_req_out, .wake_out, .irq_out);

// ---- bench/isp_core_model.sv ----
// Behavioural core that enters one interrupt per pending request episode
`timescale 1ns/1ns
module isp_core_model #(
  parameter DLY = 2
) (
  input  wire        clk_in,
  input  wire        arst_n_in,
  input  wire        high_req_in,
  input  wire        low_req_in,
  output reg         ack_out,
  output reg  [20:0] pc_out,
  output wire [7:0]  working_register_out,
  output wire [7:0]  stat_out,
  output wire [7:0]  bank_out
);
  reg  [7:0] wait_q;
  reg        served_q;
  wire       pend = high_req_in || low_req_in;
  // Working and status values move every cycle, bank value only when pc_out[12:5] steps
  assign working_register_out = pc_out[7:0] ^ 8'h5a;
  assign stat_out = pc_out[8:1];
  assign bank_out = ~pc_out[12:5];
  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      {ack_out, served_q, wait_q, pc_out} <= 31'h0;
    end else begin
      pc_out   <= pc_out + 21'h3;
      ack_out  <= pend && !served_q && wait_q == DLY;
      served_q <= pend && (served_q || ack_out);
      wait_q   <= (pend && !served_q) ? wait_q + 8'h1 : 8'h0;
    end
  end
endmodule

// ---- bench/test_isp_irq_top.sv ----
// Self-checking bench for the interrupt source block
`timescale 1ns/1ns
`include "isp_regs.vh"
module test_isp_irq_top;
  localparam [1:0] rsp_ok  = `ISP_RESP_OKAY;
  localparam [1:0] rsp_err = `ISP_RESP_SLVERR;
  reg         clk_in, arst_n_in, awvalid, wvalid, bready, arvalid, rready, tick;
  reg  [7:0]  awaddr, araddr;
  reg  [31:0] wdata;
  reg  [3:0]  pins, portb;
  reg  [20:0] pc_seen;
  reg  [23:0] ctx_seen;
  wire        awready, wready, bvalid, arready, rvalid, ack, hreq, lreq, wake, irq;
  wire [1:0]  bresp, rresp;
  wire [31:0] rdata;
  wire [20:0] pc;
  wire [7:0]  m_working_register, m_stat, m_bank;
  integer     n_errors, comparisons, i;
  isp_irq_top dut (.clk_in(clk_in), .arst_n_in(arst_n_in), .s_axi_awaddr_in(awaddr),
    .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
    .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
    .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
    .s_axi_rready_in(rready), .ext_pin_in(pins), .port_b_hi_in(portb), .timer_tick_in(tick),
    .irq_ack_in(ack), .return_pc_in(pc), .working_register_in(m_working_register),
    .core_status_in(m_stat), .bank_select_register_in(m_bank), .high_req_out(hreq),
    .low_req_out(lreq), .wake_out(wake), .irq_out(irq));
  isp_core_model #(.DLY(2)) core (.clk_in(clk_in), .arst_n_in(arst_n_in), .high_req_in(hreq),
    .low_req_in(lreq), .ack_out(ack), .pc_out(pc), .working_register_out(m_working_register), .stat_out(m_stat),
    .bank_out(m_bank));
  task check(input [31:0] got, input [31:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(posedge clk_in);
  endtask
  task wr(input [7:0] a, input [31:0] d, input [1:0] er);
    reg done;
    begin
      done = 1'b0;
      {awaddr, wdata} <= {a, d};
      {awvalid, wvalid, bready} <= 3'b111;
      while (!done) begin
        @(posedge clk_in);
        if (awready) awvalid <= 1'b0;
        if (wready) wvalid <= 1'b0;
        if (bvalid) begin
          bready <= 1'b0;
          done = 1'b1;
          check({30'h0, bresp}, {30'h0, er});
        end
      end
      @(posedge clk_in);
    end
  endtask
  task rd(input [7:0] a, input [31:0] ed, input [1:0] er);
    reg done;
    begin
      done = 1'b0;
      araddr <= a;
      {arvalid, rready} <= 2'b11;
      while (!done) begin
        @(posedge clk_in);
        if (arready) arvalid <= 1'b0;
        if (rvalid) begin
          rready <= 1'b0;
          done = 1'b1;
          check(rdata, ed);
          check({30'h0, rresp}, {30'h0, er});
        end
      end
      @(posedge clk_in);
    end
  endtask
  task ticks(input integer n);
    begin
      tick <= 1'b1;
      cyc(n);
      tick <= 1'b0;
      cyc(3);
    end
  endtask
  task do_reset;
    begin
      {pins, portb} <= 8'h0;
      arst_n_in <= 1'b0;
      cyc(8);
      arst_n_in <= 1'b1;
      cyc(1);
    end
  endtask
  task t_regs;
    begin
      rd(`ISP_OFF_CTRL_SEC, 32'h0f, rsp_ok);
      rd(`ISP_OFF_PRIO_TWO, 32'h0, rsp_ok);
      wr(`ISP_OFF_PRIO_TWO, 32'hff, rsp_ok);
      rd(`ISP_OFF_PRIO_TWO, 32'h4f, rsp_ok);
      wr(`ISP_OFF_PRIO_THR, 32'ha5, rsp_ok);
      rd(`ISP_OFF_PRIO_THR, 32'ha5, rsp_ok);
      wr(8'h2c, 32'h1, rsp_err);
      rd(8'h2c, 32'h0, rsp_err);
      wr(`ISP_OFF_TIMER, 32'h5, rsp_err);
    end
  endtask
  task t_edges;
    begin
      pins <= 4'h1;
      cyc(6);
      rd(`ISP_OFF_STATUS, 32'h01, rsp_ok);
      check({31'h0, hreq | lreq}, 32'h0);
      wr(`ISP_OFF_STATUS, 32'h01, rsp_ok);
      for (i = 1; i < 4; i = i + 1) begin
        wr(`ISP_OFF_CTRL_SEC, 32'h0f ^ (32'h1 << i), rsp_ok);
        pins[i] <= 1'b1;
        cyc(6);
        rd(`ISP_OFF_STATUS, 32'h0, rsp_ok);
        pins[i] <= 1'b0;
        cyc(6);
        rd(`ISP_OFF_STATUS, 32'h1 << i, rsp_ok);
        wr(`ISP_OFF_STATUS, 32'h1 << i, rsp_ok);
      end
    end
  endtask
  task t_prio;
    begin
      pins[0] <= 1'b0;
      cyc(6);
      pins[0] <= 1'b1;
      wr(`ISP_OFF_CTRL_MAIN, 32'h01, rsp_ok);
      cyc(8);
      check({30'h0, hreq, lreq}, 32'h2);
      rd(`ISP_OFF_STACK, {11'h0, pc_seen}, rsp_ok);
      rd(`ISP_OFF_SHADOW, {8'h0, ctx_seen}, rsp_ok);
      wr(`ISP_OFF_STATUS, 32'h01, rsp_ok);
      wr(`ISP_OFF_CTRL_THD, 32'h01, rsp_ok);
      pins[1] <= 1'b1;
      cyc(8);
      check({30'h0, hreq, lreq}, 32'h1);
      wr(`ISP_OFF_CTRL_THD, 32'h11, rsp_ok);
      cyc(3);
      check({30'h0, hreq, lreq}, 32'h2);
      wr(`ISP_OFF_STATUS, 32'h02, rsp_ok);
      wr(`ISP_OFF_CTRL_THD, 32'h0, rsp_ok);
      wr(`ISP_OFF_CTRL_MAIN, 32'h0, rsp_ok);
    end
  endtask
  task t_port;
    begin
      portb <= 4'h4;
      cyc(6);
      rd(`ISP_OFF_STATUS, 32'h20, rsp_ok);
      check({31'h0, hreq | lreq}, 32'h0);
      wr(`ISP_OFF_CTRL_MAIN, 32'h04, rsp_ok);
      cyc(3);
      check({30'h0, hreq, lreq}, 32'h1);
      wr(`ISP_OFF_CTRL_SEC, 32'h4f, rsp_ok);
      cyc(3);
      check({30'h0, hreq, lreq}, 32'h2);
      wr(`ISP_OFF_MASK, 32'h20, rsp_ok);
      cyc(3);
      check({31'h0, irq}, 32'h1);
      wr(`ISP_OFF_MASK, 32'h0, rsp_ok);
      cyc(3);
      check({31'h0, irq}, 32'h0);
      wr(`ISP_OFF_STATUS, 32'h20, rsp_ok);
      // Enable raised together with sleep must not wake
      wr(`ISP_OFF_CTRL_MAIN, 32'h11, rsp_ok);
      pins[0] <= 1'b0;
      cyc(4);
      pins[0] <= 1'b1;
      cyc(6);
      check({31'h0, wake}, 32'h0);
      wr(`ISP_OFF_STATUS, 32'h01, rsp_ok);
      wr(`ISP_OFF_CTRL_MAIN, 32'h01, rsp_ok);
      wr(`ISP_OFF_CTRL_MAIN, 32'h11, rsp_ok);
      pins[0] <= 1'b0;
      cyc(4);
      pins[0] <= 1'b1;
      cyc(6);
      check({31'h0, wake}, 32'h1);
      wr(`ISP_OFF_STATUS, 32'h01, rsp_ok);
    end
  endtask
  task t_timer;
    begin
      do_reset;
      ticks(255);
      rd(`ISP_OFF_TIMER, 32'hff, rsp_ok);
      rd(`ISP_OFF_STATUS, 32'h0, rsp_ok);
      ticks(1);
      rd(`ISP_OFF_STATUS, 32'h10, rsp_ok);
      check({30'h0, hreq, lreq}, 32'h0);
      wr(`ISP_OFF_CTRL_MAIN, 32'h02, rsp_ok);
      cyc(3);
      check({30'h0, hreq, lreq}, 32'h1);
      wr(`ISP_OFF_CTRL_SEC, 32'h2f, rsp_ok);
      cyc(3);
      check({30'h0, hreq, lreq}, 32'h2);
      wr(`ISP_OFF_STATUS, 32'h10, rsp_ok);
      do_reset;
      wr(`ISP_OFF_CTRL_MAIN, 32'h08, rsp_ok);
      ticks(65535);
      rd(`ISP_OFF_TIMER, 32'hffff, rsp_ok);
      rd(`ISP_OFF_STATUS, 32'h0, rsp_ok);
      ticks(1);
      rd(`ISP_OFF_STATUS, 32'h10, rsp_ok);
    end
  endtask
  task give_verdict;
    begin
      $display("mismatches %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  initial begin
    repeat (80000) @(posedge clk_in);
    n_errors = n_errors + 1;
    give_verdict;
  end
  always @(posedge clk_in) begin
    if (ack && (hreq || lreq)) begin
      pc_seen  <= pc;
      ctx_seen <= {m_bank, m_stat, m_working_register};
    end
  end
  initial begin
    n_errors = 0;
    comparisons = 0;
    arst_n_in = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, tick} = 6'h0;
    {awaddr, araddr, wdata, pins, portb} = 56'h0;
    repeat (8) @(posedge clk_in);
    arst_n_in <= 1'b1;
    @(posedge clk_in);
    t_regs;
    t_edges;
    t_prio;
    t_port;
    t_timer;
    give_verdict;
  end
endmodule
